// *** rtl/tbbs_pkg.sv ***
package tbbs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Printed offsets are not all multiples of four: they are indices
  localparam logic [7:0] IDX_REPEAT_COUNT = 8'ha6;
  localparam logic [7:0] IDX_ON_DURATION  = 8'ha7;
  localparam logic [7:0] IDX_OFF_DURATION = 8'ha8;
  localparam logic [7:0] IDX_CONTROL      = 8'ha0;
  localparam logic [7:0] IDX_STATUS       = 8'ha9;
  localparam int         ADDR_WIDTH       = 10;
  localparam int         ADDR_LSB         = 2;

  localparam logic [2:0] RESET_REPEAT = 3'h0;
  localparam logic [5:0] RESET_ON     = 6'h02;
  localparam logic [5:0] RESET_OFF    = 6'h01;
  localparam int         RUN_BIT      = 7;

  // ----------------------------------------------------------------
  // Field codes
  // ----------------------------------------------------------------
  localparam logic [2:0] REPEAT_INFINITE = 3'h7;
  localparam logic [2:0] REPEAT_CODE_4   = 3'h3;
  localparam logic [2:0] REPEAT_CODE_8   = 3'h4;
  localparam logic [2:0] REPEAT_CODE_16  = 3'h5;
  localparam logic [5:0] DUR_FINE_LAST   = 6'h14;
  localparam logic [5:0] DUR_COARSE_FIRST = 6'h19;
  localparam logic [5:0] DUR_CONTINUOUS  = 6'h3f;
  localparam logic [5:0] DUR_COARSE_BASE = 6'h14;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 25_000_000;
  localparam int TICK_MS      = 10;
  localparam int TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_WIDTH   = 18;
  localparam int STEP_WIDTH   = 8;
  localparam int COUNT_WIDTH  = 6;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TBBS_IDLE = 2'b00,
    TBBS_ON   = 2'b01,
    TBBS_OFF  = 2'b10,
    TBBS_STOP = 2'b11
  } tbbs_state_t;

  typedef struct packed {
    logic [2:0] repeatCode;
    logic [5:0] onCode;
    logic [5:0] offCode;
  } tbbs_cfg_t;

endpackage

// *** rtl/tbbs_duration_decode.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Duration code to count of 10 ms ticks
// ------------------------------------------------------------------
module tbbs_duration_decode (
  input  wire logic [5:0]                    durCode,
  output logic [tbbs_pkg::STEP_WIDTH-1:0]    tickCount,
  output logic                               continuous
);

  logic [tbbs_pkg::STEP_WIDTH-1:0] coarseSteps;

  always_comb begin
    coarseSteps = tbbs_pkg::STEP_WIDTH'(durCode - tbbs_pkg::DUR_COARSE_BASE);
    continuous  = (durCode == tbbs_pkg::DUR_CONTINUOUS);
    if (durCode <= tbbs_pkg::DUR_FINE_LAST) begin
      // Code zero taken as the shortest step
      tickCount = (durCode == 6'h00) ? tbbs_pkg::STEP_WIDTH'(1) :
                  tbbs_pkg::STEP_WIDTH'(durCode);
    end else if (durCode < tbbs_pkg::DUR_COARSE_FIRST) begin
      tickCount = tbbs_pkg::STEP_WIDTH'(tbbs_pkg::DUR_FINE_LAST);
    end else begin
      // 50 ms per code: 250 ms at 0x19 -> (code - 0x14) * 5 ticks
      tickCount = STEP_WIDTH_MUL5(coarseSteps);
    end
  end

  function automatic logic [tbbs_pkg::STEP_WIDTH-1:0] STEP_WIDTH_MUL5(
    input logic [tbbs_pkg::STEP_WIDTH-1:0] v
  );
    STEP_WIDTH_MUL5 = tbbs_pkg::STEP_WIDTH'({v, 2'b00} + v);
  endfunction

endmodule

// *** rtl/tbbs_repeat_decode.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Repeat code to number of beep cycles
// ------------------------------------------------------------------
module tbbs_repeat_decode (
  input  wire logic [2:0]                        repeatCode,
  output logic [tbbs_pkg::COUNT_WIDTH-1:0]       cycleTotal,
  output logic                                   infinite
);

  always_comb begin
    infinite = (repeatCode == tbbs_pkg::REPEAT_INFINITE);
    if (repeatCode <= tbbs_pkg::REPEAT_CODE_4) begin
      cycleTotal = tbbs_pkg::COUNT_WIDTH'(repeatCode) + 6'h01;
    end else if (repeatCode == tbbs_pkg::REPEAT_CODE_8) begin
      cycleTotal = 6'h08;
    end else if (repeatCode == tbbs_pkg::REPEAT_CODE_16) begin
      cycleTotal = 6'h10;
    end else begin
      cycleTotal = 6'h20;
    end
  end

endmodule

// *** rtl/tbbs_top.sv ***
`timescale 1ns/1ps
// Function
// - Repeat code selects 1-4, 8, 16, 32 cycles
// - Code 111 repeats until run cleared
// - Six-bit on duration, reset code 0x2
// - Six-bit off duration, reset code 0x1
// - Codes 0x1-0x14 give 10 ms steps
// - Codes 0x19-0x3C give 250-2000 ms
// - Code 0x3F makes phase continuous
// - Run bit self-clears after last cycle
// - Finite stop waits for cycle end
// - Continuous on-phase stop waits for zero crossing; continuous off phase goes idle at once
module tbbs_top #(
  parameter int TICK_CYCLES = tbbs_pkg::TICK_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        zeroCross,
  output logic             toneEnable,
  output logic             toneMute
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  tbbs_pkg::tbbs_cfg_t   cfg_reg;
  logic                  run_reg;
  tbbs_pkg::tbbs_state_t state_reg;
  logic [tbbs_pkg::TICK_WIDTH-1:0]  tick_reg;
  logic [tbbs_pkg::STEP_WIDTH-1:0]  step_reg;
  logic [tbbs_pkg::COUNT_WIDTH-1:0] cycle_reg;
  logic [31:0]           prdata_reg;
  logic                  pslverr_reg;

  logic [tbbs_pkg::STEP_WIDTH-1:0]  onTicks;
  logic [tbbs_pkg::STEP_WIDTH-1:0]  offTicks;
  logic [tbbs_pkg::COUNT_WIDTH-1:0] cycleTotal;
  logic                  onCont;
  logic                  offCont;
  logic                  infinite;
  logic                  continuousRun;
  logic                  tickDone;
  logic                  phaseDone;
  logic                  lastCycle;
  logic                  runClearSw;
  logic                  runSetSw;
  logic                  autoClear;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic                  access;
  logic                  wrEn;
  logic [tbbs_pkg::ADDR_WIDTH-1:0] wordIdx;
  logic                  hitRepeat;
  logic                  hitOn;
  logic                  hitOff;
  logic                  hitCtrl;
  logic                  hitStat;
  logic                  mapped;
  logic [31:0]           readMux;

  assign access    = psel && penable;
  assign wordIdx   = paddr[tbbs_pkg::ADDR_WIDTH+tbbs_pkg::ADDR_LSB-1:
                           tbbs_pkg::ADDR_LSB];
  assign hitRepeat = (wordIdx == 10'(tbbs_pkg::IDX_REPEAT_COUNT));
  assign hitOn     = (wordIdx == 10'(tbbs_pkg::IDX_ON_DURATION));
  assign hitOff    = (wordIdx == 10'(tbbs_pkg::IDX_OFF_DURATION));
  assign hitCtrl   = (wordIdx == 10'(tbbs_pkg::IDX_CONTROL));
  assign hitStat   = (wordIdx == 10'(tbbs_pkg::IDX_STATUS));
  assign mapped    = (hitRepeat || hitOn || hitOff || hitCtrl || hitStat)
                     && (paddr[1:0] == 2'b00);
  assign wrEn      = access && pwrite && pstrb[0] && mapped;
  assign pready    = psel && penable;
  assign prdata    = prdata_reg;
  assign pslverr   = pslverr_reg;

  always_comb begin
    readMux = 32'h0000_0000;
    if (mapped) begin
      if (hitRepeat) begin
        readMux[2:0] = cfg_reg.repeatCode;
      end else if (hitOn) begin
        readMux[5:0] = cfg_reg.onCode;
      end else if (hitOff) begin
        readMux[5:0] = cfg_reg.offCode;
      end else if (hitCtrl) begin
        readMux[tbbs_pkg::RUN_BIT] = run_reg;
      end else if (hitStat) begin
        readMux[1:0]  = state_reg;
        readMux[13:8] = cycle_reg;
      end
    end
  end

  // Read data launched in the setup phase so it stands through access
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_reg <= readMux;
    end
  end

  always_comb begin
    pslverr_reg = access && !mapped;
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg_reg.repeatCode <= tbbs_pkg::RESET_REPEAT;
      cfg_reg.onCode     <= tbbs_pkg::RESET_ON;
      cfg_reg.offCode    <= tbbs_pkg::RESET_OFF;
    end else if (wrEn) begin
      if (hitRepeat) begin
        cfg_reg.repeatCode <= pwdata[2:0];
      end
      if (hitOn) begin
        cfg_reg.onCode <= pwdata[5:0];
      end
      if (hitOff) begin
        cfg_reg.offCode <= pwdata[5:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  tbbs_duration_decode u_on_decode (
    .durCode    (cfg_reg.onCode),
    .tickCount  (onTicks),
    .continuous (onCont)
  );

  tbbs_duration_decode u_off_decode (
    .durCode    (cfg_reg.offCode),
    .tickCount  (offTicks),
    .continuous (offCont)
  );

  tbbs_repeat_decode u_repeat_decode (
    .repeatCode (cfg_reg.repeatCode),
    .cycleTotal (cycleTotal),
    .infinite   (infinite)
  );

  // ----------------------------------------------------------------
  // Run request
  // ----------------------------------------------------------------
  assign runSetSw   = wrEn && hitCtrl && pwdata[tbbs_pkg::RUN_BIT];
  assign runClearSw = wrEn && hitCtrl && !pwdata[tbbs_pkg::RUN_BIT];
  assign lastCycle  = !infinite && (cycle_reg == cycleTotal - 6'h01);
  assign autoClear  = (state_reg == tbbs_pkg::TBBS_OFF) && phaseDone
                      && lastCycle;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      run_reg <= 1'b0;
    end else if (runSetSw) begin
      run_reg <= 1'b1;
    end else if (autoClear) begin
      run_reg <= 1'b0;
    end else if (runClearSw) begin
      run_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  assign tickDone  = (tick_reg == tbbs_pkg::TICK_WIDTH'(
                      TICK_CYCLES - 1));
  assign phaseDone = tickDone && (step_reg == 8'h01);
  assign continuousRun = (state_reg == tbbs_pkg::TBBS_ON && onCont) ||
                         (state_reg == tbbs_pkg::TBBS_OFF && offCont);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tick_reg <= '0;
    end else if (state_reg == tbbs_pkg::TBBS_IDLE || tickDone ||
                 continuousRun) begin
      // Timebase idles in IDLE and continuous phases; it keeps counting in STOP
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_reg + 18'h00001;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= tbbs_pkg::TBBS_IDLE;
      step_reg  <= '0;
      cycle_reg <= '0;
    end else begin
      unique case (state_reg)
        tbbs_pkg::TBBS_IDLE: begin
          cycle_reg <= '0;
          if (run_reg) begin
            state_reg <= tbbs_pkg::TBBS_ON;
            step_reg  <= onTicks;
          end
        end
        tbbs_pkg::TBBS_ON: begin
          if (onCont) begin
            if (!run_reg) begin
              state_reg <= tbbs_pkg::TBBS_STOP;
            end
          end else if (tickDone) begin
            if (phaseDone) begin
              state_reg <= tbbs_pkg::TBBS_OFF;
              step_reg  <= offTicks;
            end else begin
              step_reg <= step_reg - 8'h01;
            end
          end
        end
        tbbs_pkg::TBBS_OFF: begin
          if (offCont) begin
            if (!run_reg) begin
              state_reg <= tbbs_pkg::TBBS_IDLE;
            end
          end else if (tickDone) begin
            if (phaseDone) begin
              cycle_reg <= cycle_reg + 6'h01;
              if (!run_reg || lastCycle) begin
                state_reg <= tbbs_pkg::TBBS_IDLE;
              end else begin
                state_reg <= tbbs_pkg::TBBS_ON;
                step_reg  <= onTicks;
              end
            end else begin
              step_reg <= step_reg - 8'h01;
            end
          end
        end
        tbbs_pkg::TBBS_STOP: begin
          if (zeroCross) begin
            state_reg <= tbbs_pkg::TBBS_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Tone gate outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      toneEnable <= 1'b0;
      toneMute   <= 1'b1;
    end else begin
      toneEnable <= (state_reg == tbbs_pkg::TBBS_ON) ||
                    (state_reg == tbbs_pkg::TBBS_STOP);
      toneMute   <= !((state_reg == tbbs_pkg::TBBS_ON) ||
                      (state_reg == tbbs_pkg::TBBS_STOP));
    end
  end

endmodule

// *** sim/tbbs_top_props.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module tbbs_top_props (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        zeroCross,
  input wire logic        toneEnable,
  input wire logic        toneMute
);
  localparam logic [11:0] CTRL_ADDR = {2'b00, tbbs_pkg::IDX_CONTROL, 2'b00};
  localparam logic [11:0] REP_ADDR  = {2'b00, tbbs_pkg::IDX_REPEAT_COUNT,
                                       2'b00};
  wire  acc = psel && penable;
  logic seenTone;

  // Arms the start check only until the first tone
  always_ff @(posedge sys_clk) begin
    if (srst)
      seenTone <= 1'b0;
    else if (toneEnable)
      seenTone <= 1'b1;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence run_write_s;
    acc && pwrite && pstrb[0] && paddr == CTRL_ADDR && pwdata[7] && !seenTone;
  endsequence
  sequence quiet_on_s;
    $rose(toneEnable) ##0 (!zeroCross)[*8];
  endsequence

  mute_inverse_a: assert property (toneMute == !toneEnable)
    else $error("mute is not the inverse of enable");
  ready_access_a: assert property (pready == acc)
    else $error("ready does not follow access phase");
  reset_idle_a: assert property ($fell(srst) |-> !toneEnable && toneMute)
    else $error("tone active after reset");
  misalign_err_a: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  err_read_zero_a: assert property (acc && !pwrite && pslverr |-> prdata == 0)
    else $error("refused read returns data");
  repeat_width_a: assert property (acc && !pwrite && paddr == REP_ADDR |->
    !pslverr && prdata[31:3] == 0) else $error("repeat field too wide");
  run_start_a: assert property (run_write_s |-> ##3 toneEnable)
    else $error("tone not started three cycles after run");
  on_hold_a: assert property (quiet_on_s |-> toneEnable)
    else $error("tone phase ended too early");
endmodule

bind tbbs_top tbbs_top_props u_props (.sys_clk(sys_clk), .srst(srst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .zeroCross(zeroCross), .toneEnable(toneEnable),
  .toneMute(toneMute));

// *** sim/tbbs_top_tb.sv ***
`timescale 1ns/1ps
module tbbs_top_tb;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic        zeroCross = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        toneEnable;
  logic        toneMute;
  logic [31:0] rd;
  logic        er;
  int          num_errors = 0;
  int          total_checks = 0;

  always #20 sys_clk = ~sys_clk;

  // Short tick keeps whole sequences inside the run
  tbbs_top #(.TICK_CYCLES(10)) dut (.sys_clk(sys_clk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .zeroCross(zeroCross), .toneEnable(toneEnable),
    .toneMute(toneMute));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic [7:0] idx, input logic wr,
                     input logic [31:0] wd, input logic [1:0] lo);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, lo};
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  task automatic rd_chk(input string what, input logic [7:0] idx,
                        input logic [31:0] exp, input logic experr);
    apb(idx, 1'b0, 32'h0, 2'b00);
    check(what, exp, rd);
    check("pslverr", {31'h0, experr}, {31'h0, er});
  endtask

  // Counts cycles at one tone level; with stop set, a spent bound on a wait ends the run
  task automatic span(input logic lvl, input int lim, input bit stop,
                      output int cnt);
    cnt = 0;
    while (toneEnable === lvl && cnt < lim) begin
      cnt++;
      @(posedge sys_clk);
      #1;
    end
    if (stop && cnt == lim) begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_chk("repeat", tbbs_pkg::IDX_REPEAT_COUNT, 32'h0, 1'b0);
    rd_chk("on", tbbs_pkg::IDX_ON_DURATION, 32'h2, 1'b0);
    rd_chk("off", tbbs_pkg::IDX_OFF_DURATION, 32'h1, 1'b0);
    rd_chk("control", tbbs_pkg::IDX_CONTROL, 32'h0, 1'b0);
    check("mute", 32'h1, {31'h0, toneMute});
    $display("test reset done");
  endtask

  task automatic t_regs();
    for (int i = 0; i < 8; i++) begin
      apb(tbbs_pkg::IDX_REPEAT_COUNT, 1'b1, 32'hf8 | i, 2'b00);
      rd_chk("repeat", tbbs_pkg::IDX_REPEAT_COUNT, i, 1'b0);
    end
    apb(tbbs_pkg::IDX_ON_DURATION, 1'b1, 32'hff, 2'b00);
    rd_chk("on", tbbs_pkg::IDX_ON_DURATION, 32'h3f, 1'b0);
    apb(tbbs_pkg::IDX_OFF_DURATION, 1'b1, 32'h3c, 2'b00);
    rd_chk("off", tbbs_pkg::IDX_OFF_DURATION, 32'h3c, 1'b0);
    $display("test registers done");
  endtask

  task automatic t_refuse();
    rd_chk("unmapped", 8'ha1, 32'h0, 1'b1);
    apb(tbbs_pkg::IDX_ON_DURATION, 1'b1, 32'h05, 2'b01);
    check("misaligned err", 32'h1, {31'h0, er});
    rd_chk("on kept", tbbs_pkg::IDX_ON_DURATION, 32'h3f, 1'b0);
    $display("test refusal done");
  endtask

  task automatic t_cont();
    apb(tbbs_pkg::IDX_CONTROL, 1'b1, 32'h80, 2'b00);
    repeat (2) @(posedge sys_clk);
    #1 check("tone on", 32'h1, {31'h0, toneEnable});
    rd_chk("run held", tbbs_pkg::IDX_CONTROL, 32'h80, 1'b0);
    apb(tbbs_pkg::IDX_CONTROL, 1'b1, 32'h00, 2'b00);
    repeat (50) @(posedge sys_clk);
    #1 check("tone waits", 32'h1, {31'h0, toneEnable});
    @(posedge sys_clk);
    zeroCross <= 1'b1;
    for (int n = 0; n < 10 && toneEnable !== 1'b0; n++)
      @(posedge sys_clk);
    #1 check("tone stops", 32'h0, {31'h0, toneEnable});
    check("muted", 32'h1, {31'h0, toneMute});
    @(posedge sys_clk);
    zeroCross <= 1'b0;
    $display("test continuous done");
  endtask

  task automatic t_finite();
    int c;
    apb(tbbs_pkg::IDX_REPEAT_COUNT, 1'b1, 32'h1, 2'b00);
    apb(tbbs_pkg::IDX_ON_DURATION, 1'b1, 32'h2, 2'b00);
    apb(tbbs_pkg::IDX_OFF_DURATION, 1'b1, 32'h1, 2'b00);
    apb(tbbs_pkg::IDX_CONTROL, 1'b1, 32'h80, 2'b00);
    #1 span(1'b0, 50, 1'b1, c);
    check("start delay", 32'd2, c);
    span(1'b1, 100, 1'b0, c);
    check("on ticks", 32'd20, c);
    span(1'b0, 100, 1'b0, c);
    check("off ticks", 32'd10, c);
    span(1'b1, 100, 1'b0, c);
    check("second on", 32'd20, c);
    span(1'b0, 100, 1'b0, c);
    check("no third cycle", 32'd100, c);
    rd_chk("run cleared", tbbs_pkg::IDX_CONTROL, 32'h0, 1'b0);
    apb(tbbs_pkg::IDX_REPEAT_COUNT, 1'b1, 32'h4, 2'b00);
    apb(tbbs_pkg::IDX_ON_DURATION, 1'b1, 32'h19, 2'b00);
    apb(tbbs_pkg::IDX_CONTROL, 1'b1, 32'h80, 2'b00);
    #1 span(1'b0, 50, 1'b1, c);
    apb(tbbs_pkg::IDX_CONTROL, 1'b1, 32'h00, 2'b00);
    #1 span(1'b1, 300, 1'b0, c);
    check("on after clear", 32'd247, c);
    span(1'b0, 100, 1'b0, c);
    check("stops at cycle end", 32'd100, c);
    apb(tbbs_pkg::IDX_REPEAT_COUNT, 1'b1, 32'h0, 2'b00);
    apb(tbbs_pkg::IDX_ON_DURATION, 1'b1, 32'h1, 2'b00);
    apb(tbbs_pkg::IDX_OFF_DURATION, 1'b1, 32'h3f, 2'b00);
    apb(tbbs_pkg::IDX_CONTROL, 1'b1, 32'h80, 2'b00);
    #1 span(1'b0, 50, 1'b1, c);
    span(1'b1, 100, 1'b0, c);
    check("shortest on", 32'd10, c);
    span(1'b0, 100, 1'b0, c);
    check("off held", 32'd100, c);
    rd_chk("run kept", tbbs_pkg::IDX_CONTROL, 32'h80, 1'b0);
    rd_chk("status off", tbbs_pkg::IDX_STATUS, 32'h2, 1'b0);
    apb(tbbs_pkg::IDX_CONTROL, 1'b1, 32'h00, 2'b00);
    rd_chk("status idle", tbbs_pkg::IDX_STATUS, 32'h0, 1'b0);
    $display("test finite stop done");
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_regs();
    t_refuse();
    t_cont();
    t_finite();
    tally_and_finish();
  end
endmodule
